// ### mmd_pkg.sv
package mmd_pkg;

    // ------------------------------------------------------------
    // Register offsets and reset values
    // ------------------------------------------------------------
    localparam logic [7:0]  SFR_STACK_POINTER  = 8'h81;
    localparam logic [7:0]  SFR_MEM_WRITE_SEL  = 8'h8F;
    localparam logic [7:0]  SFR_PSW            = 8'hD0;
    localparam logic [7:0]  SP_RESET           = 8'h07;
    localparam logic [7:0]  MWS_RESET          = 8'h00;
    localparam logic [7:0]  PSW_RESET          = 8'h00;
    localparam int          MWS_SEL_BIT        = 0;
    localparam int          PSW_BANK_LO        = 3;

    // ------------------------------------------------------------
    // Memory map constants
    // ------------------------------------------------------------
    localparam logic [15:0] SRAM_TOP           = 16'h03FF;
    localparam logic [15:0] DFLASH_BASE        = 16'h0400;
    localparam logic [15:0] BOOT_BASE          = 16'hF800;
    localparam logic [15:0] RESET_VECTOR       = 16'h0000;
    localparam logic [15:0] CFG_BASE           = 16'h8000;
    localparam logic [15:0] CFG_RO_LO          = 16'h8070;
    localparam logic [15:0] CFG_RO_HI          = 16'h8079;
    localparam logic [15:0] CFG_HW_ONE         = 16'h807E;
    localparam logic [15:0] CFG_HW_ZERO        = 16'h807F;
    localparam logic [7:0]  DIRECT_SFR_BASE    = 8'h80;
    localparam logic [7:0]  BIT_RAM_BASE       = 8'h20;
    localparam int          PAGE_BYTES         = 128;
    localparam logic [2:0]  HW0_PART_DEFAULT   = 3'h7;
    localparam logic [1:0]  HW0_LOCK_OFF       = 2'h3;

    // ------------------------------------------------------------
    // Targets, one-hot
    // ------------------------------------------------------------
    typedef enum logic [5:0] {
        TGT_SRAM   = 6'h01,
        TGT_PFLASH = 6'h02,
        TGT_DFLASH = 6'h04,
        TGT_BOOT   = 6'h08,
        TGT_CFG    = 6'h10,
        TGT_EXT    = 6'h20
    } mmd_target_t;

    typedef enum logic [2:0] {
        CYC_FETCH = 3'h1,
        CYC_DATA  = 3'h2,
        CYC_CFG   = 3'h4
    } mmd_cycle_t;

    typedef struct packed {
        logic        valid;
        mmd_cycle_t  cycle;
        logic        write;
        logic        erase;
        logic [15:0] addr;
        logic [7:0]  wdata;
    } mmd_req_t;

    typedef struct packed {
        mmd_target_t target;
        logic        allowed;
        logic [15:0] addr;
        logic        write;
        logic        erase;
        logic [7:0]  port0_data;
        logic        port0_drive;
    } mmd_sel_t;

endpackage : mmd_pkg

// ### mmd_memory_map_decoder.sv
`timescale 1ns/1ns
`default_nettype none

// Contract
// - Fetches above internal program top go to external program memory.
// - Data moves reach program or data flash, chosen by write-select bit.
// - With partitioning, fetches from data flash are refused.
// - Hardware config lock blocks program flash erase/write, data flash stays open.
// - Larger data partition lowers the internal program top.
// - Low data addresses hit SRAM; data flash sits directly above.
// - Data space is 64kB with 1024 bytes of SRAM.
// - Internal data accesses never drive data onto the low address/data port.
// - Flash erased before write, erase acts on 128-byte pages.
// - User mode: all configuration memory readable, none writable.
// - Programming mode: configuration writable except read-only range.
// - Hardware config bytes one and zero sit at the top two locations.
// - Config addresses are 16-bit in programming mode, 8-bit in user mode; user mode decodes only the low 7 bits.
// - Direct upper half is SFR, lower half scratchpad; upper RAM indirect only.
// - Scratchpad 20h-2Fh gives 128 addressable bits.
// - SFRs at addresses ending 0 or 8 allow single-bit access.
// - Lowest scratchpad bytes are four banks chosen by status word bits.
// - Working registers zero and one serve as indirect pointers.
// - Stack pointer resets to 07h and may be moved anywhere.
// - Stack pointer pre-increments on push, post-decrements on pop.
// - Fetch starts at address zero after any reset.
// - External-access pin low sends all fetches external.
// - Enabled boot ROM occupies the top two kilobytes of program space.
// - Unimplemented SFR reads return zero.
module mmd_memory_map_decoder
    import mmd_pkg::*;
#(
    parameter int FLASH_KB = 32
) (
    input  wire logic        sys_clk,
    input  wire logic        rst,
    input  wire logic        external_access_pin,
    input  wire logic        flash_programming_mode,
    input  wire logic        boot_rom_enable,
    input  wire logic [7:0]  hw_config_zero,
    input  wire logic [7:0]  hw_config_one,
    input  wire mmd_req_t    req,
    input  wire logic        page_erased,
    input  wire logic        reg_valid,
    input  wire logic        reg_write,
    input  wire logic        reg_bit,
    input  wire logic        reg_indirect,
    input  wire logic [7:0]  reg_addr,
    input  wire logic [2:0]  reg_bit_sel,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        stack_push,
    input  wire logic        stack_pop,
    input  wire logic [7:0]  stack_wdata,
    output mmd_sel_t         sel_q,
    output logic [15:0]      fetch_reset_addr,
    output logic [7:0]       reg_rdata_q,
    output logic [7:0]       stack_rdata_q,
    output logic [7:0]       stack_pointer_q,
    output logic [15:0]      internal_prog_top,
    output logic             unit_error_q
);

    // ------------------------------------------------------------
    // Partition decode
    // ------------------------------------------------------------
    localparam logic [16:0] FLASH_BYTES = 17'(FLASH_KB * 1024);

    // Data flash size in bytes for a partition code
    function automatic logic [16:0] dflash_bytes(input logic [2:0] part);
        logic [16:0] b;
        b = 17'h0;
        case (part)
            3'h0, 3'h1: b = FLASH_BYTES;
            3'h2:       b = (FLASH_BYTES > 17'h4000) ? 17'h4000 : FLASH_BYTES;
            3'h3:       b = (FLASH_BYTES > 17'h2000) ? 17'h2000 : FLASH_BYTES;
            3'h4:       b = (FLASH_BYTES > 17'h1000) ? 17'h1000 : FLASH_BYTES;
            3'h5:       b = 17'h0800;
            3'h6:       b = 17'h0400;
            default:    b = 17'h0;
        endcase
        return b;
    endfunction

    logic [2:0]  part_code;
    logic [16:0] dm_bytes;
    logic [16:0] pm_bytes;
    logic        prog_lock;

    assign part_code   = hw_config_zero[2:0];
    assign dm_bytes    = dflash_bytes(part_code);
    // Program region shrinks from its upper end as data grows
    assign pm_bytes    = FLASH_BYTES - dm_bytes;
    assign internal_prog_top = pm_bytes[15:0];
    // Lock field not all ones means program flash is write-protected
    assign prog_lock   = (hw_config_zero[4:3] != HW0_LOCK_OFF);
    assign fetch_reset_addr = RESET_VECTOR;

    // ------------------------------------------------------------
    // Target decode
    // ------------------------------------------------------------
    // Decoded combinationally, registered once so targets never glitch
    mmd_sel_t sel_d;
    logic [16:0] a17;
    logic        mws_sel;
    logic [7:0]  mws_q;

    assign a17     = {1'b0, req.addr};
    assign mws_sel = mws_q[MWS_SEL_BIT];

    always_comb begin
        sel_d             = '0;
        sel_d.target      = TGT_EXT;
        sel_d.addr        = req.addr;
        sel_d.write       = req.write;
        sel_d.erase       = req.erase;
        sel_d.allowed     = 1'b1;
        case (req.cycle)
            CYC_FETCH: begin
                sel_d.write = 1'b0;
                sel_d.erase = 1'b0;
                if (!external_access_pin) begin
                    sel_d.target = TGT_EXT;
                end else if (boot_rom_enable && req.addr >= BOOT_BASE) begin
                    sel_d.target = TGT_BOOT;
                end else if (a17 < pm_bytes) begin
                    sel_d.target = TGT_PFLASH;
                end else begin
                    // Data flash never lies below the program top, so it cannot execute
                    sel_d.target = TGT_EXT;
                end
            end
            CYC_DATA: begin
                if (req.addr <= SRAM_TOP) begin
                    sel_d.target = TGT_SRAM;
                end else if (!mws_sel && a17 < {1'b0, DFLASH_BASE} + dm_bytes) begin
                    sel_d.target = TGT_DFLASH;
                    sel_d.addr   = req.addr - DFLASH_BASE;
                    sel_d.allowed = !(req.write && !page_erased);
                end else if (mws_sel && a17 < pm_bytes) begin
                    sel_d.target  = TGT_PFLASH;
                    sel_d.allowed = !((req.write || req.erase) && prog_lock)
                                    && !(req.write && !page_erased);
                end else begin
                    sel_d.target = TGT_EXT;
                end
                // Erase works on whole pages only
                if (req.erase) begin
                    sel_d.addr[$clog2(PAGE_BYTES)-1:0] = '0;
                end
            end
            CYC_CFG: begin
                sel_d.target = TGT_CFG;
                sel_d.erase  = 1'b0;
                if (flash_programming_mode) begin
                    sel_d.addr = req.addr;
                    sel_d.allowed = !(req.write && req.addr >= CFG_RO_LO
                                      && req.addr <= CFG_RO_HI);
                end else begin
                    sel_d.addr    = CFG_BASE | {8'h00, 1'b0, req.addr[6:0]};
                    sel_d.allowed = !req.write;
                end
            end
            default: begin
                sel_d.allowed = 1'b0;
            end
        endcase
        // Internal transfers keep the multiplexed port quiet
        sel_d.port0_drive = (sel_d.target == TGT_EXT) && req.write;
        sel_d.port0_data  = sel_d.port0_drive ? req.wdata : 8'h00;
    end

    // Registered target, one-hot while a request is valid, all zero when idle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sel_q <= '0;
        end else if (req.valid) begin
            sel_q <= sel_d;
        end else begin
            sel_q <= '0;
        end
    end

    // ------------------------------------------------------------
    // Scratchpad and SFRs
    // ------------------------------------------------------------
    logic [7:0] scratch [0:255];
    logic [7:0] sp_q;
    logic [7:0] psw_q;
    logic [7:0] ra;
    logic       is_sfr;
    logic [7:0] bitbyte;
    logic [2:0] bitpos;

    // Bit address to byte address for scratch or SFR space
    function automatic logic [7:0] bit_byte(input logic [7:0] b);
        return b[7] ? {b[7:3], 3'h0} : (BIT_RAM_BASE + {4'h0, b[6:3]});
    endfunction

    always_comb begin
        ra     = reg_addr;
        is_sfr = 1'b0;
        bitpos = reg_bit_sel;
        if (reg_bit) begin
            ra     = bit_byte(reg_addr);
            bitpos = reg_addr[2:0];
            is_sfr = reg_addr[7];
        end else if (reg_indirect) begin
            // Pointer in working register zero or one of active bank
            ra     = scratch[{3'h0, psw_q[PSW_BANK_LO+1:PSW_BANK_LO], 2'h0, reg_addr[0]}];
        end else if (reg_addr >= DIRECT_SFR_BASE) begin
            is_sfr = 1'b1;
        end else if (reg_addr[7:3] == 5'h00) begin
            // Working registers map through the bank select bits
            ra = {3'h0, psw_q[PSW_BANK_LO+1:PSW_BANK_LO], reg_addr[2:0]};
        end
        bitbyte = is_sfr ? 8'h00 : scratch[ra];
    end

    // Scratchpad writes, including stack pushes
    always_ff @(posedge sys_clk) begin
        if (stack_push) begin
            scratch[sp_q + 8'h01] <= stack_wdata;
        end else if (reg_valid && reg_write && !is_sfr) begin
            if (reg_bit) begin
                scratch[ra] <= bitbyte & ~(8'h01 << bitpos) | ({7'h0, reg_wdata[0]} << bitpos);
            end else begin
                scratch[ra] <= reg_wdata;
            end
        end
    end

    // Stack pointer; push/pop beat software writes in the same cycle
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            sp_q <= SP_RESET;
        end else if (stack_push) begin
            sp_q <= sp_q + 8'h01;
        end else if (stack_pop) begin
            sp_q <= sp_q - 8'h01;
        end else if (reg_valid && reg_write && is_sfr && ra == SFR_STACK_POINTER) begin
            sp_q <= reg_wdata;
        end
    end

    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            stack_rdata_q <= 8'h00;
        end else if (stack_pop) begin
            stack_rdata_q <= scratch[sp_q];
        end
    end

    // Write-select and status word SFRs
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            mws_q <= MWS_RESET;
            psw_q <= PSW_RESET;
        end else if (reg_valid && reg_write && is_sfr) begin
            if (ra == SFR_MEM_WRITE_SEL && !reg_bit) begin
                mws_q <= reg_wdata;
            end else if (ra == SFR_PSW) begin
                if (reg_bit) begin
                    psw_q[bitpos] <= reg_wdata[0];
                end else begin
                    psw_q <= reg_wdata;
                end
            end
        end
    end

    // Register reads; unknown SFRs read as zero
    always_ff @(posedge sys_clk or posedge rst) begin
        if (rst) begin
            reg_rdata_q  <= 8'h00;
            unit_error_q <= 1'b0;
        end else if (reg_valid && !reg_write) begin
            unit_error_q <= 1'b0;
            if (!is_sfr) begin
                reg_rdata_q <= reg_bit ? {7'h0, bitbyte[bitpos]} : bitbyte;
            end else if (ra == SFR_STACK_POINTER && !reg_bit) begin
                reg_rdata_q <= sp_q;
            end else if (ra == SFR_MEM_WRITE_SEL && !reg_bit) begin
                reg_rdata_q <= mws_q;
            end else if (ra == SFR_PSW) begin
                reg_rdata_q <= reg_bit ? {7'h0, psw_q[bitpos]} : psw_q;
            end else begin
                reg_rdata_q  <= 8'h00;
                unit_error_q <= 1'b1;
            end
        end
    end

    assign stack_pointer_q = sp_q;

endmodule : mmd_memory_map_decoder

`default_nettype wire

// ### mmd_memory_map_decoder_sva.sv
`timescale 1ns/1ns
`default_nettype none

module mmd_memory_map_decoder_chk
    import mmd_pkg::*;
#(
    parameter int FLASH_KB = 32
) (
    input wire logic        sys_clk,
    input wire logic        rst,
    input wire logic        external_access_pin,
    input wire logic        flash_programming_mode,
    input wire logic        boot_rom_enable,
    input wire mmd_req_t    req,
    input wire logic        reg_valid,
    input wire logic        stack_push,
    input wire logic        stack_pop,
    input wire mmd_sel_t    sel_q,
    input wire logic [15:0] fetch_reset_addr,
    input wire logic [7:0]  stack_pointer_q,
    input wire logic [15:0] internal_prog_top
);
    // ------------------------------------------------------------
    // Decode and stack properties, all in the system clock domain
    // ------------------------------------------------------------
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (rst);

    a_ext_pin_low: assert property (req.valid && req.cycle == CYC_FETCH && !external_access_pin
        |=> sel_q.target == TGT_EXT) else $error("fetch with access pin low not external");
    a_above_top: assert property (req.valid && req.cycle == CYC_FETCH && external_access_pin
        && !boot_rom_enable && req.addr >= internal_prog_top
        |=> sel_q.target == TGT_EXT) else $error("fetch above program top not external");
    a_boot_top: assert property (req.valid && req.cycle == CYC_FETCH && external_access_pin
        && boot_rom_enable && req.addr >= BOOT_BASE
        |=> sel_q.target == TGT_BOOT) else $error("top fetch missed boot rom");
    a_sram_low: assert property (req.valid && req.cycle == CYC_DATA && req.addr <= SRAM_TOP
        |=> sel_q.target == TGT_SRAM) else $error("low data address missed sram");
    a_port0_quiet: assert property (sel_q.target != TGT_EXT |-> !sel_q.port0_drive)
        else $error("internal access drove port zero");
    a_one_target: assert property (req.valid |=> $onehot(sel_q.target))
        else $error("access selected not exactly one target");
    a_idle_clear: assert property (!req.valid |=> sel_q == '0)
        else $error("selection stood without a request");
    a_user_cfg_ro: assert property (req.valid && req.cycle == CYC_CFG && req.write
        && !flash_programming_mode |=> !sel_q.allowed) else $error("user mode config write");
    a_ro_range: assert property (req.valid && req.cycle == CYC_CFG && req.write
        && flash_programming_mode && req.addr inside {[CFG_RO_LO:CFG_RO_HI]}
        |=> !sel_q.allowed) else $error("read-only config location written");
    a_push_inc: assert property (stack_push
        |=> stack_pointer_q == $past(stack_pointer_q) + 8'h01) else $error("push did not add one");
    a_pop_dec: assert property (stack_pop && !stack_push && !reg_valid
        |=> stack_pointer_q == $past(stack_pointer_q) - 8'h01) else $error("pop did not sub one");
    a_sp_reset: assert property ($fell(rst) |-> stack_pointer_q == SP_RESET)
        else $error("stack pointer not at reset value");
    a_vector_zero: assert property (fetch_reset_addr == RESET_VECTOR)
        else $error("reset fetch address not zero");
endmodule // mmd_memory_map_decoder_chk

`default_nettype wire

// ### mmd_cpu_model.sv
`timescale 1ns/1ns
`default_nettype none

module mmd_cpu_model
    import mmd_pkg::*;
(
    input  wire logic     sys_clk,
    output var  mmd_req_t req
);
    // ------------------------------------------------------------
    // One request per call, held across exactly one taking edge
    // ------------------------------------------------------------
    initial req = '0;

    // Erase is a flag on the same request, so nothing here orders a page clear before a write to it
    task automatic access(input mmd_cycle_t cyc, input logic wr, input logic er,
                          input logic [15:0] a);
        @(negedge sys_clk);
        req <= '{valid: 1'b1, cycle: cyc, write: wr, erase: er, addr: a, wdata: 8'hA5};
        @(negedge sys_clk);
        req <= '0; // Released where the answer is sampled, so no stale request lingers
    endtask
endmodule // mmd_cpu_model

`default_nettype wire

// ### memory_map_decoder_test.sv
`timescale 1ns/1ns
`default_nettype none

module memory_map_decoder_test;
    import mmd_pkg::*;
    localparam int FLASH_KB = 32;
    logic sys_clk, rst, external_access_pin, flash_programming_mode, boot_rom_enable;
    logic page_erased, reg_valid, reg_write, stack_push, stack_pop, unit_error_q;
    logic [7:0] hw_config_zero, hw_config_one, reg_addr, reg_wdata;
    logic [7:0] reg_rdata_q, stack_rdata_q, stack_pointer_q;
    logic [15:0] fetch_reset_addr, internal_prog_top;
    mmd_req_t req;
    mmd_sel_t sel_q;
    int fail_count = 0;
    int checked = 0;

    mmd_cpu_model cpu (.sys_clk(sys_clk), .req(req));
    mmd_memory_map_decoder #(.FLASH_KB(FLASH_KB)) dut (.sys_clk(sys_clk), .rst(rst),
        .external_access_pin(external_access_pin), .flash_programming_mode(flash_programming_mode),
        .boot_rom_enable(boot_rom_enable), .hw_config_zero(hw_config_zero),
        .hw_config_one(hw_config_one), .req(req), .page_erased(page_erased),
        .reg_valid(reg_valid), .reg_write(reg_write), .reg_bit(1'b0), .reg_indirect(1'b0),
        .reg_addr(reg_addr), .reg_bit_sel(3'h0), .reg_wdata(reg_wdata),
        .stack_push(stack_push), .stack_pop(stack_pop), .stack_wdata(8'h3C), .sel_q(sel_q),
        .fetch_reset_addr(fetch_reset_addr), .reg_rdata_q(reg_rdata_q),
        .stack_rdata_q(stack_rdata_q), .stack_pointer_q(stack_pointer_q),
        .internal_prog_top(internal_prog_top), .unit_error_q(unit_error_q));

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    initial begin
        sys_clk = 1'b0;
        forever #5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            fail_count++;
            $display("MISMATCH t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask

    task automatic acc(input mmd_cycle_t c, input logic wr, input logic [15:0] a,
                       input mmd_target_t t, input logic ok);
        cpu.access(c, wr, 1'b0, a);
        chk(16'(sel_q.target), 16'(t));
        chk(16'(sel_q.allowed), 16'(ok));
    endtask

    // Register access lasts one edge; read data is looked at once it has landed
    task automatic reg_acc(input logic wr, input logic [7:0] a, input logic [7:0] d);
        @(negedge sys_clk);
        reg_valid = 1'b1;
        reg_write = wr;
        reg_addr = a;
        reg_wdata = d;
        @(negedge sys_clk);
        reg_valid = 1'b0;
    endtask

    task automatic stk(input logic psh, input logic pp);
        @(negedge sys_clk);
        stack_push = psh;
        stack_pop = pp;
        @(negedge sys_clk);
        stack_push = 1'b0;
        stack_pop = 1'b0;
    endtask

    task automatic wrap_up;
        $display("checks=%0d mismatches=%0d", checked, fail_count);
        if (fail_count == 0 && checked > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    // Whole sequence needs well under a thousand cycles
    initial begin
        #20000;
        fail_count++;
        wrap_up();
    end

    // ------------------------------------------------------------
    // Tests
    // ------------------------------------------------------------
    initial begin
        rst = 1'b1;
        {external_access_pin, page_erased} = 2'b11;
        {flash_programming_mode, boot_rom_enable, reg_valid, reg_write} = 4'h0;
        {stack_push, stack_pop, reg_addr, reg_wdata} = '0;
        hw_config_zero = 8'h1F; // Unlocked, full program partition
        hw_config_one = 8'h00;
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        rst = 1'b0;
        chk(16'(stack_pointer_q), 16'(SP_RESET));
        chk(fetch_reset_addr, 16'h0000);
        chk(internal_prog_top, 16'(FLASH_KB * 1024));
        acc(CYC_FETCH, 1'b0, 16'h0000, TGT_PFLASH, 1'b1);
        $display("test reset done");
        hw_config_zero = 8'h1E; // One kilobyte of data flash
        @(negedge sys_clk);
        chk(internal_prog_top, 16'(FLASH_KB * 1024 - 1024));
        acc(CYC_FETCH, 1'b0, 16'(FLASH_KB * 1024 - 1025), TGT_PFLASH, 1'b1);
        acc(CYC_FETCH, 1'b0, 16'(FLASH_KB * 1024 - 1024), TGT_EXT, 1'b1);
        acc(CYC_DATA, 1'b0, 16'h03FF, TGT_SRAM, 1'b1);
        acc(CYC_DATA, 1'b0, 16'h0400, TGT_DFLASH, 1'b1);
        chk(sel_q.addr, 16'h0000);
        acc(CYC_DATA, 1'b0, 16'h07FF, TGT_DFLASH, 1'b1);
        acc(CYC_DATA, 1'b0, 16'h0800, TGT_EXT, 1'b1);
        acc(CYC_FETCH, 1'b0, 16'hF800, TGT_EXT, 1'b1);
        boot_rom_enable = 1'b1;
        acc(CYC_FETCH, 1'b0, 16'hF800, TGT_BOOT, 1'b1);
        acc(CYC_FETCH, 1'b0, 16'hFFFF, TGT_BOOT, 1'b1);
        {boot_rom_enable, external_access_pin} = 2'b00;
        acc(CYC_FETCH, 1'b0, 16'h0000, TGT_EXT, 1'b1);
        external_access_pin = 1'b1;
        $display("test partition done");
        reg_acc(1'b1, SFR_MEM_WRITE_SEL, 8'h01);
        reg_acc(1'b0, SFR_MEM_WRITE_SEL, 8'h00);
        chk(16'(reg_rdata_q), 16'h0001);
        acc(CYC_DATA, 1'b1, 16'h1000, TGT_PFLASH, 1'b1);
        hw_config_zero = 8'h06; // Program flash locked
        acc(CYC_DATA, 1'b1, 16'h1000, TGT_PFLASH, 1'b0);
        reg_acc(1'b1, SFR_MEM_WRITE_SEL, 8'h00);
        acc(CYC_DATA, 1'b1, 16'h0400, TGT_DFLASH, 1'b1);
        page_erased = 1'b0;
        acc(CYC_DATA, 1'b1, 16'h0400, TGT_DFLASH, 1'b0);
        page_erased = 1'b1;
        $display("test flash write done");
        acc(CYC_CFG, 1'b1, 16'h8000, TGT_CFG, 1'b0);
        acc(CYC_CFG, 1'b0, 16'h807F, TGT_CFG, 1'b1);
        acc(CYC_CFG, 1'b0, 16'h007E, TGT_CFG, 1'b1);
        chk(sel_q.addr, CFG_HW_ONE);
        flash_programming_mode = 1'b1;
        acc(CYC_CFG, 1'b1, 16'h8070, TGT_CFG, 1'b0);
        acc(CYC_CFG, 1'b1, 16'h8079, TGT_CFG, 1'b0);
        acc(CYC_CFG, 1'b1, 16'h806F, TGT_CFG, 1'b1);
        acc(CYC_CFG, 1'b1, 16'h807E, TGT_CFG, 1'b1);
        flash_programming_mode = 1'b0;
        $display("test config done");
        stk(1'b1, 1'b0);
        stk(1'b1, 1'b0);
        chk(16'(stack_pointer_q), 16'h0009);
        stk(1'b0, 1'b1);
        chk(16'(stack_pointer_q), 16'h0008);
        chk(16'(stack_rdata_q), 16'h003C);
        reg_acc(1'b1, SFR_STACK_POINTER, 8'hE0);
        chk(16'(stack_pointer_q), 16'h00E0);
        reg_acc(1'b1, SFR_PSW, 8'h18);
        reg_acc(1'b0, SFR_PSW, 8'h00);
        chk(16'(reg_rdata_q), 16'h0018);
        reg_acc(1'b1, 8'h00, 8'h5A);
        reg_acc(1'b0, 8'h18, 8'h00);
        chk(16'(reg_rdata_q), 16'h005A);
        reg_acc(0, 8'hA5, 8'h00);
        chk(16'(reg_rdata_q), 16'h0000);
        chk(16'(unit_error_q), 16'h0001);
        rst = 1'b1; // Second reset in mid-run
        @(negedge sys_clk);
        rst = 1'b0;
        chk(16'(stack_pointer_q), 16'(SP_RESET));
        $display("test registers done");
        wrap_up();
    end
endmodule // memory_map_decoder_test

bind mmd_memory_map_decoder mmd_memory_map_decoder_chk #(.FLASH_KB(FLASH_KB)) u_chk (
    .sys_clk(sys_clk), .rst(rst), .external_access_pin(external_access_pin),
    .flash_programming_mode(flash_programming_mode), .boot_rom_enable(boot_rom_enable),
    .req(req), .reg_valid(reg_valid), .stack_push(stack_push), .stack_pop(stack_pop),
    .sel_q(sel_q), .fetch_reset_addr(fetch_reset_addr), .stack_pointer_q(stack_pointer_q),
    .internal_prog_top(internal_prog_top));

`default_nettype wire
